// ### rtl/asc_pkg.sv
/*
 Shared constants and types for the converter sequencer control.
 Assumes a single system clock; no register bus, all controls are plain ports.
*/
package asc_pkg;
	// Conversion length in conversion clocks per channel
	localparam int CONV_CLOCKS = 86;
	// Conversion clock divider codes
	localparam logic [1:0] DIV_BY2 = 2'h0;
	localparam logic [1:0] DIV_BY4 = 2'h1;
	localparam logic [1:0] DIV_BY8 = 2'h2;
	// Delay in conversion clocks before results are readable
	localparam logic [1:0] READY_FIXED = 2'h1;
	localparam logic [1:0] READY_SCAN = 2'h2;
	// Result low byte layout
	localparam int LOW_FLAG_POS = 0;
	localparam logic [4:0] LOW_FILL = 5'h1F;
	// Reset values
	localparam logic [9:0] RESULT_RST = 10'h000;
	localparam logic [1:0] QUAD_RST = 2'h0;
	typedef enum logic [1:0] {ASC_IDLE, ASC_CONV, ASC_GAP} asc_state_t;
endpackage

// ### rtl/asc_tick_gen.sv
/*
 Conversion clock enable generator: one-cycle tick every 2, 4 or 8 system clocks.
 Assumes the divider select is stable while a conversion runs.
*/
`timescale 1ns/100ps
`default_nettype none
module asc_tick_gen
	import asc_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic run_i,
	input wire logic [1:0] div_sel_i,
	output logic tick_o
);
	logic [2:0] cnt_reg;
	logic [2:0] cnt_next;
	logic tick_next;
	logic [2:0] last;

	// Terminal count per divider; reserved code behaves as divide by eight
	always_comb begin
		unique case (div_sel_i)
			DIV_BY2: last = 3'h1;
			DIV_BY4: last = 3'h3;
			default: last = 3'h7;
		endcase
		cnt_next = 3'h0;
		tick_next = 1'b0;
		if (run_i) begin
			if (cnt_reg >= last) begin
				tick_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + 3'h1;
			end
		end
	end

	// Counter restarts on each run so a restart is phase aligned
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			cnt_reg <= 3'h0;
			tick_o <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tick_o <= tick_next;
		end
	end

	// A tick is a one-cycle enable, never a level
	property p_tick_single;
		@(posedge clock_i) disable iff (!rst_n_i) tick_o |=> !tick_o;
	endproperty
	a_tick_single: assert property (p_tick_single) else $error("tick held longer than a cycle");
endmodule
`default_nettype wire

// ### rtl/asc_seq_ctrl.sv
/*
 Sequencer control for an eight-input 10-bit converter: start, modes,
 channel selection, flags, result routing. Assumes an analog core that
 samples conv_channel_o and delivers core_result_i at the end of conversion.
*/
`timescale 1ns/100ps
`default_nettype none
module asc_seq_ctrl
	import asc_pkg::*;
#(
	parameter int RES_W = 10,
	parameter int CONV_LEN = CONV_CLOCKS
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic conv_start_bit_i,
	input wire logic ext_trigger_in_n_i,
	input wire logic ext_trigger_enable_i,
	input wire logic repeat_i,
	input wire logic scan_i,
	input wire logic irq_every_fourth_i,
	input wire logic [2:0] channel_select_code_i,
	input wire logic [1:0] conv_clock_divider_i,
	input wire logic standby_i,
	input wire logic standby_run_enable_i,
	input wire logic [RES_W-1:0] core_result_i,
	input wire logic [3:0] read_pair_i,
	output logic conv_busy_flag_o,
	output logic end_of_conv_flag_o,
	output logic conv_done_irq_o,
	output logic core_sample_o,
	output logic [2:0] conv_channel_o,
	output logic results_ready_o,
	output logic [31:0] result_high_o,
	output logic [31:0] result_low_o
);
	// Result packing and the 7-bit counter bound what can be served
	if (RES_W != 10 || CONV_LEN < 2 || CONV_LEN > 127) begin : g_param_check
		$error("asc_seq_ctrl: unsupported parameters");
	end

	logic tick;
	asc_state_t state_reg, state_next;
	logic [6:0] cnt_reg, cnt_next;
	logic [2:0] chan_reg, chan_next;
	logic [1:0] quad_reg, quad_next;
	logic [1:0] wait_reg, wait_next;
	logic trig_reg;
	logic busy_next, eoc_next, irq_next, sample_next, ready_next;
	logic [3:0] stored_reg, stored_next;
	logic [RES_W-1:0] res_reg [4];
	logic [RES_W-1:0] res_next [4];
	logic halted_reg, halted_next;
	logic start_req, trig_fall, last_chan, conv_end, load;
	logic [1:0] pair_sel;
	logic [2:0] first_chan;

	asc_tick_gen u_tick (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.run_i(state_reg != ASC_IDLE),
		.div_sel_i(conv_clock_divider_i),
		.tick_o(tick)
	);

	////////////////////////////////////////////////////////////////
	// Start request decode
	always_comb begin
		trig_fall = trig_reg && !ext_trigger_in_n_i;
		// Trigger only counts while nothing converts
		start_req = conv_start_bit_i || (ext_trigger_enable_i && trig_fall && !conv_busy_flag_o);
		first_chan = scan_i ? {channel_select_code_i[2], 2'h0} : channel_select_code_i;
		last_chan = !scan_i || (chan_reg == channel_select_code_i);
		conv_end = (state_reg == ASC_CONV) && tick && (cnt_reg == 7'(CONV_LEN - 1));
		pair_sel = (repeat_i && !scan_i) ? quad_reg : chan_reg[1:0];
	end

	////////////////////////////////////////////////////////////////
	// Sequencer next state
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		chan_next = chan_reg;
		quad_next = quad_reg;
		wait_next = wait_reg;
		busy_next = conv_busy_flag_o;
		eoc_next = end_of_conv_flag_o;
		irq_next = 1'b0;
		sample_next = 1'b0;
		ready_next = results_ready_o;
		halted_next = halted_reg;
		load = 1'b0;
		if (state_reg == ASC_CONV && tick) begin
			cnt_next = cnt_reg + 7'h01;
		end
		if (conv_end) begin
			load = 1'b1;
			quad_next = quad_reg + 2'h1;
			if (!last_chan) begin
				chan_next = chan_reg + 3'h1;
				cnt_next = 7'h00;
				sample_next = 1'b1;
			end else begin
				eoc_next = 1'b1;
				ready_next = 1'b0;
				wait_next = scan_i ? READY_SCAN : READY_FIXED;
				irq_next = !(repeat_i && !scan_i && irq_every_fourth_i) || (quad_reg == 2'h3);
				state_next = ASC_GAP;
				busy_next = repeat_i;
			end
		end
		// Post-completion window before results are readable
		if (state_reg == ASC_GAP && tick) begin
			wait_next = wait_reg - 2'h1;
			if (wait_reg == 2'h1) begin
				ready_next = 1'b1;
				if (repeat_i) begin
					state_next = ASC_CONV;
					chan_next = first_chan;
					cnt_next = 7'h00;
					sample_next = 1'b1;
				end else begin
					state_next = ASC_IDLE;
					busy_next = 1'b0;
				end
			end
		end
		if (|read_pair_i) begin
			eoc_next = 1'b0;
		end
		if (conv_end && last_chan) begin
			eoc_next = 1'b1;
		end
		if (start_req) begin
			state_next = ASC_CONV;
			chan_next = first_chan;
			cnt_next = 7'h00;
			quad_next = QUAD_RST;
			busy_next = 1'b1;
			sample_next = 1'b1;
			load = 1'b0;
			irq_next = 1'b0;
		end
		// Standby halts at once; repeating sequences resume after
		if (standby_i && !standby_run_enable_i) begin
			if (state_reg != ASC_IDLE) begin
				halted_next = repeat_i;
			end
			state_next = ASC_IDLE;
			busy_next = 1'b0;
			sample_next = 1'b0;
			irq_next = 1'b0;
			load = 1'b0;
		end else if (halted_reg) begin
			halted_next = 1'b0;
			state_next = repeat_i ? ASC_CONV : ASC_IDLE;
			chan_next = first_chan;
			cnt_next = 7'h00;
			quad_next = QUAD_RST;
			busy_next = repeat_i;
			sample_next = repeat_i;
		end
	end

	////////////////////////////////////////////////////////////////
	// Result pairs and stored flags, loaded by the converter only
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			res_next[i] = res_reg[i];
			stored_next[i] = stored_reg[i] && !read_pair_i[i];
			if (load && pair_sel == 2'(i)) begin
				res_next[i] = core_result_i;
				stored_next[i] = 1'b1;
			end
		end
	end

	// Register stage; outputs all come straight from flops
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			state_reg <= ASC_IDLE;
			cnt_reg <= 7'h00;
			chan_reg <= 3'h0;
			quad_reg <= QUAD_RST;
			wait_reg <= 2'h0;
			trig_reg <= 1'b1;
			halted_reg <= 1'b0;
			stored_reg <= 4'h0;
			conv_busy_flag_o <= 1'b0;
			end_of_conv_flag_o <= 1'b0;
			conv_done_irq_o <= 1'b0;
			core_sample_o <= 1'b0;
			conv_channel_o <= 3'h0;
			results_ready_o <= 1'b1;
			for (int i = 0; i < 4; i++) begin
				res_reg[i] <= RESULT_RST;
			end
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			chan_reg <= chan_next;
			quad_reg <= quad_next;
			wait_reg <= wait_next;
			trig_reg <= ext_trigger_in_n_i;
			halted_reg <= halted_next;
			stored_reg <= stored_next;
			conv_busy_flag_o <= busy_next;
			end_of_conv_flag_o <= eoc_next;
			conv_done_irq_o <= irq_next;
			core_sample_o <= sample_next;
			conv_channel_o <= chan_next;
			results_ready_o <= ready_next;
			res_reg <= res_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Packed read view: high byte, low two bits, ones fill, stored flag
	generate
		for (genvar g = 0; g < 4; g++) begin : g_pair
			always_ff @(posedge clock_i) begin
				if (!rst_n_i) begin
					result_high_o[8*g +: 8] <= 8'h00;
					result_low_o[8*g +: 8] <= {2'h0, LOW_FILL, 1'b0};
				end else begin
					result_high_o[8*g +: 8] <= res_next[g][9:2];
					result_low_o[8*g +: 8] <= {res_next[g][1:0], LOW_FILL, stored_next[g]};
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	sequence s_start;
		start_req && !(standby_i && !standby_run_enable_i);
	endsequence
	property p_busy_on_start;
		@(posedge clock_i) disable iff (!rst_n_i) s_start |=> conv_busy_flag_o && core_sample_o;
	endproperty
	a_busy_on_start: assert property (p_busy_on_start) else $error("busy not set on start");
	property p_trig_ignored;
		@(posedge clock_i) disable iff (!rst_n_i)
			(conv_busy_flag_o && trig_fall && ext_trigger_enable_i && !conv_start_bit_i
				&& state_reg == ASC_CONV && !conv_end) |=> !core_sample_o;
	endproperty
	a_trig_ignored: assert property (p_trig_ignored) else $error("trigger accepted while busy");
	property p_single_done;
		@(posedge clock_i) disable iff (!rst_n_i)
			(conv_end && last_chan && !repeat_i && !start_req && !standby_i) |=> !conv_busy_flag_o && end_of_conv_flag_o;
	endproperty
	a_single_done: assert property (p_single_done) else $error("single mode completion wrong");
	property p_repeat_busy;
		@(posedge clock_i) disable iff (!rst_n_i)
			(conv_end && repeat_i && !standby_i) |=> conv_busy_flag_o;
	endproperty
	a_repeat_busy: assert property (p_repeat_busy) else $error("busy dropped in repeat mode");
	property p_standby_halt;
		@(posedge clock_i) disable iff (!rst_n_i)
			(standby_i && !standby_run_enable_i) |=> state_reg == ASC_IDLE && !conv_busy_flag_o;
	endproperty
	a_standby_halt: assert property (p_standby_halt) else $error("standby did not halt");
	property p_stored_clear;
		@(posedge clock_i) disable iff (!rst_n_i) (read_pair_i[0] && !load) |=> !stored_reg[0];
	endproperty
	a_stored_clear: assert property (p_stored_clear) else $error("stored flag not cleared on read");
	property p_eoc_clear;
		@(posedge clock_i) disable iff (!rst_n_i) (|read_pair_i && !conv_end) |=> !end_of_conv_flag_o;
	endproperty
	a_eoc_clear: assert property (p_eoc_clear) else $error("eoc not cleared on read");
	property p_ready_late;
		@(posedge clock_i) disable iff (!rst_n_i) (conv_end && last_chan) |=> !results_ready_o;
	endproperty
	a_ready_late: assert property (p_ready_late) else $error("results ready too early");
endmodule
`default_nettype wire

// ### tb/asc_core_model.sv
/*
 Behavioural model of the analog core and the external trigger pin.
 Assumes the sequencer pulses sample_i for one cycle when a channel is picked.
*/
`timescale 1ns/100ps
`default_nettype none
module asc_core_model (
	input wire logic clock_i,
	input wire logic sample_i,
	input wire logic [2:0] channel_i,
	input wire logic fire_i,
	output logic [9:0] result_o,
	output logic trig_n_o
);
	logic [2:0] held_reg = 3'h0;
	logic [1:0] low_reg = 2'h0;
	////////////////////////////////////////////////////////////////
	// Channel latched at sampling; trigger held low three cycles
	always @(posedge clock_i) begin
		if (sample_i === 1'b1) held_reg <= channel_i;
		if (fire_i === 1'b1) low_reg <= 2'h3;
		else if (low_reg != 2'h0) low_reg <= low_reg - 2'h1;
	end
	// Result encodes the channel, so misrouting shows up
	assign result_o = {held_reg, 4'hA, held_reg};
	// Pin rests high by its pull-up between pulses
	assign trig_n_o = (low_reg == 2'h0);
endmodule
`default_nettype wire

// ### tb/adc_sequencer_control_bench.sv
/*
 Self-checking bench for the sequencer control: a row table of single
 conversions, then scan, repeat, trigger, abort and standby cases.
 Assumes a short conversion length set through CONV_LEN.
*/
`timescale 1ns/100ps
`default_nettype none
module adc_sequencer_control_bench
	import asc_pkg::*;
;
	localparam int CL = 4;
	typedef struct packed {logic [2:0] ch; logic [1:0] dv; logic [3:0] nd; logic [1:0] pr;} asc_row_t;
	logic clock_i = 0, rst_n_i = 0, st = 0, ten = 0, rep = 0, scn = 0, e4 = 0, stb = 0, fire = 0, sre = 0;
	logic [2:0] ch = 3'h0, chan;
	logic [1:0] dv = 2'h0;
	logic [3:0] rdp = 4'h0;
	logic [9:0] res;
	logic trig_n, busy, eoc, irq, samp, ready;
	logic [31:0] hi, lo;
	logic [2:0] q[$];
	asc_row_t rows[8];
	asc_row_t r;
	int bad_count = 0, n_tests = 0, t;
	////////////////////////////////////////////////////////////////
	// Clock and instances
	always #12.5 clock_i = ~clock_i;
	asc_seq_ctrl #(.CONV_LEN(CL)) u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .conv_start_bit_i(st),
		.ext_trigger_in_n_i(trig_n), .ext_trigger_enable_i(ten), .repeat_i(rep), .scan_i(scn),
		.irq_every_fourth_i(e4), .channel_select_code_i(ch), .conv_clock_divider_i(dv), .standby_i(stb),
		.standby_run_enable_i(sre), .core_result_i(res), .read_pair_i(rdp), .conv_busy_flag_o(busy),
		.end_of_conv_flag_o(eoc), .conv_done_irq_o(irq), .core_sample_o(samp), .conv_channel_o(chan),
		.results_ready_o(ready), .result_high_o(hi), .result_low_o(lo));
	asc_core_model u_core (.clock_i(clock_i), .sample_i(samp), .channel_i(chan), .fire_i(fire),
		.result_o(res), .trig_n_o(trig_n));
	// Record every channel handed to the core
	always @(posedge clock_i) if (samp === 1'b1) q.push_back(chan);
	////////////////////////////////////////////////////////////////
	// Shared tasks; inputs move 2 ns after the edge
	task automatic tick; @(posedge clock_i); #2; endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic go; st = 1; tick; st = 0; tick; endtask
	task automatic pull; fire = 1; tick; fire = 0; endtask
	task automatic rd(input logic [3:0] p); rdp = p; tick; rdp = 4'h0; tick; endtask
	// Bounded wait, so a missing interrupt cannot hang the run
	task automatic wait_irq(output int n);
		n = 0;
		while (irq !== 1'b1 && n < 600) begin
			tick;
			n++;
		end
		if (n >= 600) chk(0, 1);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		#1000000;
		bad_count++;
		stop_test;
	end
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rows = '{'{3'h0, 2'h0, 4'h2, 2'h0}, '{3'h1, 2'h1, 4'h4, 2'h1}, '{3'h2, 2'h2, 4'h8, 2'h2},
			'{3'h3, 2'h3, 4'h8, 2'h3}, '{3'h4, 2'h0, 4'h2, 2'h0}, '{3'h5, 2'h1, 4'h4, 2'h1},
			'{3'h6, 2'h2, 4'h8, 2'h2}, '{3'h7, 2'h3, 4'h8, 2'h3}};
		repeat (12) @(posedge clock_i);
		#2 rst_n_i = 1;
		tick;
		chk(busy, 0);
		chk(lo, 32'h3E3E3E3E);
		chk(ready, 1);
		$display("reset test done");
		foreach (rows[i]) begin
			r = rows[i];
			ch = r.ch;
			dv = r.dv;
			q.delete();
			go;
			chk(busy, 1);
			wait_irq(t);
			chk(t >= CL * r.nd - 2 && t <= CL * r.nd + r.nd + 4, 1);
			chk({eoc, busy, ready}, 3'h4);
			chk(q.size(), 1);
			chk(q[0], r.ch);
			chk(hi[8 * r.pr +: 8], {r.ch, 4'hA, r.ch[2]});
			chk(lo[8 * r.pr +: 8], {r.ch[1:0], 5'h1F, 1'b1});
			// One conversion clock of the row's divider before results stand
			repeat (r.nd - 1) tick;
			chk(ready, 0);
			tick;
			chk(ready, 1);
			repeat (20) tick;
			rd(4'h1 << r.pr);
			chk({lo[8 * r.pr], eoc}, 2'h0);
		end
		$display("single conversion table done");
		scn = 1;
		ch = 3'h6;
		dv = 2'h0;
		q.delete();
		go;
		wait_irq(t);
		chk(q.size(), 3);
		chk({q[0], q[1], q[2]}, {3'h4, 3'h5, 3'h6});
		chk(busy, 0);
		// Scan waits two conversion clocks, four system clocks here
		repeat (3) tick;
		chk(ready, 0);
		tick;
		chk(ready, 1);
		$display("scan test done");
		// Mode bits change only once the sequencer is idle again
		repeat (20) tick;
		scn = 0;
		rep = 1;
		e4 = 1;
		ch = 3'h5;
		rd(4'hF);
		q.delete();
		go;
		wait_irq(t);
		chk(q.size(), 4);
		chk(busy, 1);
		chk({lo[24], lo[16], lo[8], lo[0]}, 4'hF);
		// Clear repeat three cycles after the fifth conversion starts
		repeat (5) tick;
		rep = 0;
		e4 = 0;
		wait_irq(t);
		chk(busy, 0);
		repeat (40) tick;
		chk(q.size(), 5);
		$display("repeat test done");
		ten = 1;
		q.delete();
		pull;
		wait_irq(t);
		chk(q.size(), 1);
		repeat (20) tick;
		q.delete();
		pull;
		repeat (3) tick;
		pull;
		wait_irq(t);
		repeat (40) tick;
		chk(q.size(), 1);
		// Trigger edge and start bit taken at the same edge
		q.delete();
		pull;
		st = 1;
		tick;
		st = 0;
		wait_irq(t);
		repeat (40) tick;
		chk(q.size(), 1);
		ten = 0;
		$display("trigger test done");
		q.delete();
		go;
		repeat (3) tick;
		go;
		wait_irq(t);
		chk(q.size(), 2);
		chk(t >= CL * 2 - 2, 1);
		$display("abort test done");
		repeat (20) tick;
		q.delete();
		go;
		repeat (3) tick;
		stb = 1;
		repeat (3) tick;
		chk(busy, 0);
		stb = 0;
		repeat (40) tick;
		chk({busy, q.size() == 1}, 2'h1);
		// Standby with run enable leaves the conversion alone
		sre = 1;
		go;
		repeat (3) tick;
		stb = 1;
		wait_irq(t);
		stb = 0;
		sre = 0;
		chk(q.size(), 2);
		repeat (20) tick;
		scn = 1;
		rep = 1;
		ch = 3'h2;
		q.delete();
		go;
		wait_irq(t);
		chk(q.size(), 3);
		chk(busy, 1);
		stb = 1;
		repeat (3) tick;
		chk(busy, 0);
		stb = 0;
		tick;
		chk(busy, 1);
		rep = 0;
		wait_irq(t);
		chk(busy, 0);
		chk({q.size() == 6, q[3]}, 4'h8);
		scn = 0;
		$display("standby test done");
		stop_test;
	end
endmodule
`default_nettype wire
